// >>> ctsc_pkg.sv
// constants for the clock trim and sleep control block
// Contract
// - reset loads factory calibration byte into trim
// - software may rewrite trim at any time
// - trim top bit picks frequency range
// - low seven trim bits tune within range
// - unused clock and sleep bits read zero
// - select without crystal enable clears both
// - select bit routes slow RC or crystal
// - power-down and power-off stop async oscillators, others conditional
// - active: crystal follows enable, slow RC on
// - sleep needs arm bit plus SLEEP instruction
// - wake stalls four cycles beyond start-up
// - state kept across wake except power-off
// - reset during sleep restarts at reset vector
// - leaving power-off always goes through reset
// - mode field bits 3:1 encodes five modes
// - armed power-off code auto-clears after four cycles
// - idle halts only CPU and flash clocks
// - noise reduction halts I/O, CPU, flash clocks
// - power-save stops fast RC oscillator; slow RC runs only with select set and a peripheral enabled
// - power-down stops fast, crystal, slow oscillators
package ctsc_pkg;

  // register port
  localparam int ADDR_W = 2;
  localparam int DATA_W = 8;
  localparam logic [1:0] TRIM_OFF = 2'h0;
  localparam logic [1:0] CLKCTRL_OFF = 2'h1;
  localparam logic [1:0] SLEEPCTRL_OFF = 2'h2;

  // field positions
  localparam int TRIM_RANGE_BIT = 7;
  localparam int TRIM_FINE_MSB = 6;
  localparam int CC_ACS_BIT = 0;
  localparam int CC_XOE_BIT = 1;
  localparam int SC_ARM_BIT = 0;
  localparam int SC_MODE_LSB = 1;
  localparam int SC_MODE_MSB = 3;

  // reset values
  localparam logic RST_XOE = 1'h0;
  localparam logic RST_ACS = 1'h0;
  localparam logic RST_ARM = 1'h0;
  localparam logic [2:0] RST_MODE = 3'h0;

  // sleep mode codes
  localparam logic [2:0] MODE_IDLE = 3'h0;
  localparam logic [2:0] MODE_ADCNR = 3'h1;
  localparam logic [2:0] MODE_DOWN = 3'h2;
  localparam logic [2:0] MODE_SAVE = 3'h3;
  localparam logic [2:0] MODE_OFF = 3'h4;

  // timing in cycles of the CPU clock
  localparam int CLK_HZ = 25_000_000;
  localparam int STALL_CYCLES = 4;
  localparam int STARTUP_CK = 6;
  localparam int PO_WINDOW_CYCLES = 4;
  localparam int WAKE_CNT_W = 4;

endpackage

// >>> ctsc_wake_timer.sv
// down counter that times start-up and stall after a wake-up
`timescale 1ns/100ps
module ctsc_wake_timer import ctsc_pkg::*; (
  // clock and reset
  input logic clock_in,
  input logic rst_in,
  // control
  input logic load_in,
  input logic [WAKE_CNT_W-1:0] count_in,
  // status
  output logic done_out
);

  logic [WAKE_CNT_W-1:0] count;

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      count <= '0;
    end else if (load_in) begin
      count <= count_in;
    end else if (count != '0) begin
      count <= count - 1'b1;
    end
  end

  // high in the last counted cycle
  assign done_out = (count == WAKE_CNT_W'(1)) && !load_in;

endmodule

// >>> ctsc_top.sv
// clock trim, async clock select and sleep mode control
`timescale 1ns/100ps
module ctsc_top import ctsc_pkg::*; (
  // clock and reset
  input logic clock_in,
  input logic rst_in,
  // register port
  input logic [ADDR_W-1:0] addr_in,
  input logic [DATA_W-1:0] wr_data_in,
  input logic wr_en_in,
  input logic rd_en_in,
  output logic [DATA_W-1:0] rd_data_out,
  // factory trim and peripheral enables
  input logic [DATA_W-1:0] cal_byte_in,
  input logic cc_adc_enable_in,
  input logic wakeup_timer_enable_in,
  // cpu handshake
  input logic sleep_exec_in,
  input logic wake_irq_in,
  output logic irq_entry_out,
  output logic sleeping_out,
  // oscillator control
  output logic trim_range_select_out,
  output logic [TRIM_FINE_MSB:0] trim_fine_value_out,
  output logic fast_rc_osc_en_out,
  output logic crystal_osc_en_out,
  output logic slow_rc_osc_en_out,
  output logic async_clk_sel_out,
  // clock gates and power
  output logic cpu_clk_en_out,
  output logic flash_clk_en_out,
  output logic io_clk_en_out,
  output logic regulator_off_out,
  output logic ram_retain_out
);

  typedef enum logic [1:0] {
    ST_ACTIVE,
    ST_SLEEP,
    ST_WAKE,
    ST_OFF
  } ctsc_state_type;

  localparam logic [2:0] PO_LAST = 3'(PO_WINDOW_CYCLES - 1);
  localparam logic [WAKE_CNT_W-1:0] WAKE_SHORT = WAKE_CNT_W'(STALL_CYCLES);
  localparam logic [WAKE_CNT_W-1:0] WAKE_LONG =
    WAKE_CNT_W'(STARTUP_CK + STALL_CYCLES);

  ctsc_state_type state;
  ctsc_state_type next_state;
  logic [DATA_W-1:0] trim;
  logic crystal_enable;
  logic async_clock_select;
  logic arm;
  logic [2:0] mode;
  logic [2:0] held_mode;
  logic [2:0] po_cnt;
  logic po_armed;
  logic mode_legal;
  logic sleep_go;
  logic wr_trim;
  logic wr_clk;
  logic wr_sleep;
  logic timer_load;
  logic timer_done;
  logic [WAKE_CNT_W-1:0] timer_count;
  logic deep_mode;
  logic [DATA_W-1:0] next_rd_data;

  assign wr_trim = wr_en_in && (addr_in == TRIM_OFF);
  assign wr_clk = wr_en_in && (addr_in == CLKCTRL_OFF);
  assign wr_sleep = wr_en_in && (addr_in == SLEEPCTRL_OFF);

  // trim register
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      trim <= cal_byte_in;
    end else if (wr_trim) begin
      trim <= wr_data_in;
    end
  end

  // oscillator tuning fields go straight to the analog trim
  assign trim_range_select_out = trim[TRIM_RANGE_BIT];
  assign trim_fine_value_out = trim[TRIM_FINE_MSB:0];

  // clock control register
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      crystal_enable <= RST_XOE;
      async_clock_select <= RST_ACS;
    end else if (wr_clk) begin
      if (wr_data_in[CC_ACS_BIT] && !wr_data_in[CC_XOE_BIT]) begin
        crystal_enable <= 1'b0;
        async_clock_select <= 1'b0;
      end else begin
        crystal_enable <= wr_data_in[CC_XOE_BIT];
        async_clock_select <= wr_data_in[CC_ACS_BIT];
      end
    end
  end

  // async source routing for coulomb counter and wake-up timer
  assign async_clk_sel_out = async_clock_select;

  // sleep control register
  assign po_armed = arm && (mode == MODE_OFF);

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      arm <= RST_ARM;
      mode <= RST_MODE;
    end else if (wr_sleep) begin
      arm <= wr_data_in[SC_ARM_BIT];
      mode <= wr_data_in[SC_MODE_MSB:SC_MODE_LSB];
    end else if (po_armed && (po_cnt == PO_LAST)) begin
      arm <= RST_ARM;
      mode <= RST_MODE;
    end
  end

  // cycles the power-off request has stood armed
  always_ff @(posedge clock_in) begin
    if (rst_in || wr_sleep || !po_armed) begin
      po_cnt <= '0;
    end else begin
      po_cnt <= po_cnt + 3'h1;
    end
  end

  // register read port, data in the cycle after the strobe
  always_comb begin
    next_rd_data = '0;
    unique case (addr_in)
      TRIM_OFF: next_rd_data = trim;
      CLKCTRL_OFF: begin
        next_rd_data[CC_XOE_BIT] = crystal_enable;
        next_rd_data[CC_ACS_BIT] = async_clock_select;
      end
      SLEEPCTRL_OFF: begin
        next_rd_data[SC_MODE_MSB:SC_MODE_LSB] = mode;
        next_rd_data[SC_ARM_BIT] = arm;
      end
      default: next_rd_data = '0;
    endcase
  end

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      rd_data_out <= '0;
    end else if (rd_en_in) begin
      rd_data_out <= next_rd_data;
    end else begin
      rd_data_out <= '0;
    end
  end

  // sleep entry and wake sequencing
  assign mode_legal = (mode <= MODE_OFF);
  assign sleep_go = (state == ST_ACTIVE) && sleep_exec_in && arm && mode_legal;
  assign deep_mode = (held_mode == MODE_DOWN) || (held_mode == MODE_SAVE);
  assign timer_load = (state == ST_SLEEP) && wake_irq_in;
  assign timer_count = deep_mode ? WAKE_LONG : WAKE_SHORT;

  always_comb begin
    next_state = state;
    unique case (state)
      ST_ACTIVE: begin
        if (sleep_go) begin
          next_state = (mode == MODE_OFF) ? ST_OFF : ST_SLEEP;
        end
      end
      ST_SLEEP: begin
        if (wake_irq_in) begin
          next_state = ST_WAKE;
        end
      end
      ST_WAKE: begin
        if (timer_done) begin
          next_state = ST_ACTIVE;
        end
      end
      // only reset leaves power-off
      ST_OFF: next_state = ST_OFF;
    endcase
  end

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      state <= ST_ACTIVE;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      held_mode <= MODE_IDLE;
    end else if (sleep_go) begin
      held_mode <= mode;
    end
  end

  ctsc_wake_timer u_wake_timer (
    .clock_in(clock_in),
    .rst_in(rst_in),
    .load_in(timer_load),
    .count_in(timer_count),
    .done_out(timer_done)
  );

  // handler entry, then execution resumes after SLEEP
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      irq_entry_out <= 1'b0;
    end else begin
      irq_entry_out <= (state == ST_WAKE) && timer_done;
    end
  end

  // power and retention
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      sleeping_out <= 1'b0;
      regulator_off_out <= 1'b0;
      ram_retain_out <= 1'b1;
    end else begin
      sleeping_out <= (state != ST_ACTIVE);
      regulator_off_out <= (state == ST_OFF);
      ram_retain_out <= (state != ST_OFF);
    end
  end

  // clock gates and oscillator enables per state
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      cpu_clk_en_out <= 1'b1;
      flash_clk_en_out <= 1'b1;
      io_clk_en_out <= 1'b1;
      fast_rc_osc_en_out <= 1'b1;
      crystal_osc_en_out <= 1'b0;
      slow_rc_osc_en_out <= 1'b1;
    end else begin
      unique case (state)
        ST_ACTIVE: begin
          cpu_clk_en_out <= 1'b1;
          flash_clk_en_out <= 1'b1;
          io_clk_en_out <= 1'b1;
          fast_rc_osc_en_out <= 1'b1;
          crystal_osc_en_out <= crystal_enable;
          slow_rc_osc_en_out <= 1'b1;
        end
        ST_SLEEP: begin
          cpu_clk_en_out <= 1'b0;
          flash_clk_en_out <= 1'b0;
          io_clk_en_out <= (held_mode == MODE_IDLE);
          fast_rc_osc_en_out <= (held_mode == MODE_IDLE)
            || (held_mode == MODE_ADCNR);
          if (held_mode == MODE_DOWN) begin
            crystal_osc_en_out <= 1'b0;
            slow_rc_osc_en_out <= 1'b0;
          end else begin
            crystal_osc_en_out <= crystal_enable;
            slow_rc_osc_en_out <= async_clock_select
              && (cc_adc_enable_in || wakeup_timer_enable_in);
          end
        end
        ST_WAKE: begin
          cpu_clk_en_out <= 1'b0;
          flash_clk_en_out <= 1'b0;
          io_clk_en_out <= 1'b1;
          fast_rc_osc_en_out <= 1'b1;
          crystal_osc_en_out <= crystal_enable;
          slow_rc_osc_en_out <= 1'b1;
        end
        ST_OFF: begin
          cpu_clk_en_out <= 1'b0;
          flash_clk_en_out <= 1'b0;
          io_clk_en_out <= 1'b0;
          fast_rc_osc_en_out <= 1'b0;
          crystal_osc_en_out <= 1'b0;
          slow_rc_osc_en_out <= 1'b0;
        end
      endcase
    end
  end

  // checks
  sequence s_idle_wake;
    (state == ST_SLEEP) && wake_irq_in && (held_mode == MODE_IDLE);
  endsequence

  sequence s_po_write;
    wr_sleep && wr_data_in[SC_ARM_BIT]
      && (wr_data_in[SC_MODE_MSB:SC_MODE_LSB] == MODE_OFF);
  endsequence

  a_trim_reset_load: assert property (@(posedge clock_in)
    rst_in |=> (trim == $past(cal_byte_in)))
    else $error("trim not loaded from calibration byte");

  a_trim_sw_write: assert property (@(posedge clock_in)
    disable iff (rst_in) wr_trim |=> (trim_fine_value_out == $past(wr_data_in[6:0])))
    else $error("trim write not applied");

  a_xtal_sel_guard: assert property (@(posedge clock_in)
    disable iff (rst_in)
    (wr_clk && wr_data_in[CC_ACS_BIT] && !wr_data_in[CC_XOE_BIT])
      |=> !async_clk_sel_out && !crystal_enable)
    else $error("crystal selected while disabled");

  a_reserved_read_zero: assert property (@(posedge clock_in)
    disable iff (rst_in)
    (rd_en_in && (addr_in == CLKCTRL_OFF)) |=> (rd_data_out[7:2] == 6'h00))
    else $error("reserved clock control bits not zero");

  a_sleep_needs_arm: assert property (@(posedge clock_in)
    disable iff (rst_in)
    ((state == ST_ACTIVE) && !arm) |=> (state == ST_ACTIVE))
    else $error("sleep entered without arm bit");

  a_reserved_no_sleep: assert property (@(posedge clock_in)
    disable iff (rst_in)
    ((state == ST_ACTIVE) && (mode > MODE_OFF)) |=> (state == ST_ACTIVE))
    else $error("reserved mode entered sleep");

  a_po_auto_clear: assert property (@(posedge clock_in)
    disable iff (rst_in)
    s_po_write ##1 (!wr_sleep) [*4] |=> (!arm && (mode == MODE_OFF - 3'h4)))
    else $error("power-off request not cleared after four cycles");

  a_idle_wake_stall: assert property (@(posedge clock_in)
    disable iff (rst_in)
    s_idle_wake |-> (!irq_entry_out [*5] ##1 irq_entry_out))
    else $error("idle wake stall length wrong");

  a_off_needs_reset: assert property (@(posedge clock_in)
    disable iff (rst_in)
    (state == ST_OFF) |=> (state == ST_OFF) && !ram_retain_out)
    else $error("power-off left without reset");

  a_deep_osc_off: assert property (@(posedge clock_in)
    disable iff (rst_in)
    ((state == ST_SLEEP) && (held_mode == MODE_DOWN))
      |=> (!crystal_osc_en_out && !slow_rc_osc_en_out && !fast_rc_osc_en_out))
    else $error("oscillator running in power-down");

endmodule

// >>> ctsc_cpu_model.sv
// cpu core model: register accesses and the sleep instruction
`timescale 1ns/100ps
module ctsc_cpu_model import ctsc_pkg::*; #(
  parameter int STAB_CYCLES = 20
) (
  // clock
  input wire logic clock_in,
  // register port
  output logic [ADDR_W-1:0] addr_out,
  output logic [DATA_W-1:0] wr_data_out,
  output logic wr_en_out,
  output logic rd_en_out,
  input wire logic [DATA_W-1:0] rd_data_in,
  // sleep instruction
  output logic sleep_exec_out
);
  initial begin
    addr_out = 2'h0;
    wr_data_out = 8'h00;
    wr_en_out = 1'h0;
    rd_en_out = 1'h0;
    sleep_exec_out = 1'h0;
  end

  // called at a rising edge; a gap cycle follows each access
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    addr_out <= a;
    wr_data_out <= d;
    wr_en_out <= 1'h1;
    @(posedge clock_in);
    wr_en_out <= 1'h0;
    @(posedge clock_in);
  endtask

  task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
    addr_out <= a;
    rd_en_out <= 1'h1;
    @(posedge clock_in);
    rd_en_out <= 1'h0;
    #1 d = rd_data_in;
    @(posedge clock_in);
  endtask

  task automatic sleep_now();
    sleep_exec_out <= 1'h1;
    @(posedge clock_in);
    sleep_exec_out <= 1'h0;
    @(posedge clock_in);
  endtask

  // arm and mode, then sleep two cycles later, inside the power-off window
  task automatic enter_sleep(input logic [2:0] m);
    wr(SLEEPCTRL_OFF, {4'h0, m, 1'h1});
    sleep_now();
  endtask

  // stabilisation wait is shortened to STAB_CYCLES
  task automatic to_crystal();
    wr(CLKCTRL_OFF, 8'h02);
    repeat (STAB_CYCLES) @(posedge clock_in);
    wr(CLKCTRL_OFF, 8'h03);
  endtask

  task automatic to_rc();
    wr(CLKCTRL_OFF, 8'h02);
    wr(CLKCTRL_OFF, 8'h00);
  endtask
endmodule

// >>> ctsc_top_tb_top.sv
// testbench for the clock trim, async clock select and sleep control block
`timescale 1ns/100ps
module ctsc_top_tb_top import ctsc_pkg::*;;
  logic clock_in, rst_in, wr_en, rd_en, sleep_exec, wake_irq, cc_adc, wakeup_timer;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wr_data, rd_data, cal_byte, d;
  logic irq_entry, sleeping, range_sel, fast, xtal, slow, async_clock_select, cpu, flash, io, reg_off, ram;
  logic [TRIM_FINE_MSB:0] fine;
  logic [7:0] tv [3] = '{8'h7F, 8'h80, 8'h00};
  int error_cnt = 0;
  int samples_checked = 0;
  int k;
  logic [2:0] m;
  wire logic [7:0] vec = {cpu, flash, io, fast, xtal, slow, reg_off, ram};

  ctsc_top i_dut (.clock_in(clock_in), .rst_in(rst_in), .addr_in(addr), .wr_data_in(wr_data),
    .wr_en_in(wr_en), .rd_en_in(rd_en), .rd_data_out(rd_data), .cal_byte_in(cal_byte),
    .cc_adc_enable_in(cc_adc), .wakeup_timer_enable_in(wakeup_timer), .sleep_exec_in(sleep_exec),
    .wake_irq_in(wake_irq), .irq_entry_out(irq_entry), .sleeping_out(sleeping),
    .trim_range_select_out(range_sel), .trim_fine_value_out(fine), .fast_rc_osc_en_out(fast),
    .crystal_osc_en_out(xtal), .slow_rc_osc_en_out(slow), .async_clk_sel_out(async_clock_select),
    .cpu_clk_en_out(cpu), .flash_clk_en_out(flash), .io_clk_en_out(io),
    .regulator_off_out(reg_off), .ram_retain_out(ram));

  ctsc_cpu_model i_cpu (.clock_in(clock_in), .addr_out(addr), .wr_data_out(wr_data),
    .wr_en_out(wr_en), .rd_en_out(rd_en), .rd_data_in(rd_data), .sleep_exec_out(sleep_exec));

  initial begin
    clock_in = 1'h0;
    forever #20 clock_in = ~clock_in;
  end

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic cmp(input string what, input logic [7:0] exp, input logic [7:0] seen);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic chk_rd(input logic [ADDR_W-1:0] a, input logic [7:0] exp, input string what);
    i_cpu.rd(a, d);
    cmp(what, exp, d);
  endtask

  task automatic do_reset();
    rst_in <= 1'h1;
    repeat (8) @(posedge clock_in);
    rst_in <= 1'h0;
    @(posedge clock_in);
  endtask

  // expected {cpu,flash,io,fast,crystal,slow,regulator_off,ram_retain} with crystal on
  function automatic logic [7:0] exp_vec(input logic [2:0] md, input logic s);
    case (md)
      MODE_IDLE: exp_vec = {4'h3, 1'h1, s, 2'h1};
      MODE_ADCNR: exp_vec = {4'h1, 1'h1, s, 2'h1};
      MODE_SAVE: exp_vec = {4'h0, 1'h1, s, 2'h1};
      MODE_DOWN: exp_vec = 8'h01;
      default: exp_vec = 8'h02;
    endcase
  endfunction

  task automatic wake_and_time();
    @(posedge clock_in);
    wake_irq <= 1'h1;
    @(posedge clock_in);
    wake_irq <= 1'h0;
    k = 1;
    #1;
    while (irq_entry !== 1'h1 && k < 40) begin
      @(posedge clock_in);
      #1;
      k++;
    end
  endtask

  initial begin
    repeat (5000) @(posedge clock_in);
    error_cnt++;
    report_and_stop();
  end

  initial begin
    rst_in = 1'h1;
    cal_byte = 8'h5A;
    cc_adc = 1'h0;
    wakeup_timer = 1'h0;
    wake_irq = 1'h0;
    @(posedge clock_in);
    do_reset();
    chk_rd(TRIM_OFF, 8'h5A, "trim reset");
    cmp("active outputs", 8'hF5, vec);
    foreach (tv[i]) begin
      i_cpu.wr(TRIM_OFF, tv[i]);
      chk_rd(TRIM_OFF, tv[i], "trim rw");
      cmp("trim outputs", tv[i], {range_sel, fine});
    end
    i_cpu.wr(CLKCTRL_OFF, 8'hFF);
    chk_rd(CLKCTRL_OFF, 8'h03, "clock ctrl");
    i_cpu.wr(CLKCTRL_OFF, 8'h01);
    chk_rd(CLKCTRL_OFF, 8'h00, "select without enable");
    i_cpu.wr(SLEEPCTRL_OFF, 8'hFF);
    chk_rd(SLEEPCTRL_OFF, 8'h0F, "sleep ctrl");
    i_cpu.wr(2'h3, 8'hFF);
    chk_rd(2'h3, 8'h00, "unmapped");
    chk_rd(TRIM_OFF, 8'h00, "trim kept");
    i_cpu.to_crystal();
    chk_rd(CLKCTRL_OFF, 8'h03, "to crystal");
    cmp("crystal selected", {7'h7E, 1'h1}, {vec[7:1], async_clock_select});
    i_cpu.to_rc();
    chk_rd(CLKCTRL_OFF, 8'h00, "to rc");
    cmp("rc selected", {7'h7A, 1'h0}, {vec[7:1], async_clock_select});
    i_cpu.wr(SLEEPCTRL_OFF, 8'h00);
    i_cpu.sleep_now();
    cmp("sleep unarmed", 8'h00, {7'h00, sleeping});
    for (int i = 5; i < 8; i++) begin
      i_cpu.enter_sleep(i[2:0]);
      @(posedge clock_in);
      cmp("reserved mode", 8'hF4, {vec[7:1], sleeping});
    end
    i_cpu.to_crystal();
    for (int i = 0; i < 4; i++) begin
      m = i[2:0];
      cc_adc <= m[0];
      wakeup_timer <= m[1];
      i_cpu.enter_sleep(m);
      #1;
      cmp("sleep outputs", exp_vec(m, m[0] | m[1]), vec);
      cmp("sleeping", 8'h01, {7'h00, sleeping});
      wake_and_time();
      k = k - ((m == MODE_DOWN || m == MODE_SAVE) ? STARTUP_CK : 0);
      cmp("wake latency", 8'(STALL_CYCLES + 1), 8'(k));
      @(posedge clock_in);
      #1;
      cmp("irq pulse", 8'h00, {7'h00, irq_entry});
      @(posedge clock_in);
      cmp("awake", 8'hFC, {vec[7:1], sleeping});
      chk_rd(SLEEPCTRL_OFF, {4'h0, m, 1'h1}, "sleep ctrl kept");
      chk_rd(TRIM_OFF, 8'h00, "trim kept");
    end
    i_cpu.wr(SLEEPCTRL_OFF, 8'h09);
    repeat (2) @(posedge clock_in);
    chk_rd(SLEEPCTRL_OFF, 8'h09, "off code held");
    i_cpu.wr(SLEEPCTRL_OFF, 8'h09);
    repeat (3) @(posedge clock_in);
    chk_rd(SLEEPCTRL_OFF, 8'h00, "off code cleared");
    i_cpu.enter_sleep(MODE_OFF);
    #1;
    cmp("power off", 8'h02, vec);
    wake_and_time();
    cmp("no irq wake from off", 8'h01, {7'h00, sleeping});
    @(posedge clock_in);
    cal_byte <= 8'hA7;
    do_reset();
    chk_rd(TRIM_OFF, 8'hA7, "trim after off");
    cmp("after off", 8'hF4, {vec[7:1], sleeping});
    report_and_stop();
  end
endmodule
